//--- hw/crl_buffer.sv
// shared configuration image and trace buffer with apb register access
`timescale 1ns/1ps
module crl_buffer
(
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire crl_pkg::crl_rom_req_s ROM_REQ,
  output crl_pkg::crl_rom_ans_s      ROM_ANS,
  input  wire crl_pkg::crl_trace_s   TRACE_IN
);
  import crl_pkg::*;

  // ==========================================================
  // storage and configuration
  logic [31:0] mem [BUF_QUADS];
  logic [7:0]  ar_size;
  logic [7:0]  tx_sb_size;
  logic [7:0]  rx_sb_size;
  logic [7:0]  tx_pt_size;
  logic [7:0]  rx_pt_size;
  logic [11:0] img_bytes;
  logic        sel;
  logic        img_valid;
  logic        short_fmt;
  logic [N_TYPES-1:0] trace_en;
  logic [11:0] ptr;
  logic [6:0]  wr_pos;
  logic [6:0]  rd_pos;
  logic [6:0]  count;
  logic [31:0] prdata_q;
  logic        err_q;

  // ==========================================================
  // partition of the shared buffer
  wire [9:0] used_sum = {2'h0, ar_size} + {2'h0, tx_pt_size}
                      + {2'h0, rx_pt_size} + {2'h0, tx_sb_size}
                      + {2'h0, rx_sb_size};
  wire       size_fault = used_sum > {2'h0, BUF_QUADS_B};
  wire [7:0] trace_size = size_fault ? 8'h00
                        : BUF_QUADS_B - used_sum[7:0];
  wire [7:0] trace_base = BUF_QUADS_B - trace_size;
  wire       trace_full = {1'b0, count} == trace_size;
  wire       trace_empty = count == 7'h00;

  // ==========================================================
  // apb decode
  wire setup  = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire hit_ar   = PADDR == OFF_AR_SIZE;
  wire hit_sb   = PADDR == OFF_SB_SIZES;
  wire hit_pt   = PADDR == OFF_PT_SIZES;
  wire hit_img  = PADDR == OFF_IMG_BYTES;
  wire hit_ctl  = PADDR == OFF_CONTROL;
  wire hit_data = PADDR == OFF_DATA;
  wire mapped = hit_ar | hit_sb | hit_pt | hit_img | hit_ctl | hit_data;
  wire wr_acc = access & PWRITE & mapped;
  wire rd_acc = access & ~PWRITE & mapped;

  // ==========================================================
  // image pointer window
  wire [11:0] ptr_rel  = ptr - IMAGE_BASE;
  wire [9:0]  ptr_quad = ptr_rel[11:2];
  wire        ptr_in   = (ptr >= IMAGE_BASE)
                       & (ptr_quad < {2'h0, ar_size});
  wire [6:0]  ptr_idx  = ptr_quad[6:0];

  wire        data_wr  = wr_acc & hit_data;
  wire        data_rd  = rd_acc & hit_data;
  wire        img_wr   = data_wr & sel & ptr_in;
  wire        ptr_step = (data_wr | data_rd) & sel;
  wire        pop      = data_rd & ~sel & ~trace_empty;

  // ==========================================================
  // trace capture
  wire kind_keep = ~(short_fmt & (TRACE_IN.kind == CRL_PAYLOAD));
  wire push = TRACE_IN.valid & trace_en[TRACE_IN.ttype]
            & kind_keep & (trace_size != 8'h00);
  wire [6:0] wr_next = ({1'b0, wr_pos} + 8'h01 == trace_size)
                     ? 7'h00 : wr_pos + 7'h01;
  wire [6:0] rd_next = ({1'b0, rd_pos} + 8'h01 == trace_size)
                     ? 7'h00 : rd_pos + 7'h01;
  wire [7:0] wr_abs  = trace_base + {1'b0, wr_pos};
  wire [7:0] rd_abs  = trace_base + {1'b0, rd_pos};
  // a push into a full area drops the oldest quadlet
  wire drop_old = push & trace_full & ~pop;

  // ==========================================================
  // register read mux, sampled in the setup cycle
  wire [31:0] ctl_view;
  assign ctl_view = {5'h00, ptr[10:0], 1'b0,
                     count,
                     trace_en, size_fault, short_fmt, img_valid, sel};
  wire [31:0] data_view = sel ? (ptr_in ? mem[ptr_idx] : 32'h0)
                        : (trace_empty ? 32'h0 : mem[rd_abs[6:0]]);
  wire [31:0] rd_mux =
      hit_ar   ? {24'h0, ar_size} :
      hit_sb   ? {16'h0, rx_sb_size, tx_sb_size} :
      hit_pt   ? {16'h0, rx_pt_size, tx_pt_size} :
      hit_img  ? {20'h0, img_bytes} :
      hit_ctl  ? ctl_view :
      hit_data ? data_view : 32'h0;

  assign PREADY  = PENABLE;
  assign PRDATA  = prdata_q;
  assign PSLVERR = err_q & access;

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      prdata_q <= 32'h0;
      err_q    <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= PWRITE ? 32'h0 : rd_mux;
      err_q    <= ~mapped;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ar_size    <= RST_SIZE;
      tx_sb_size <= RST_SIZE;
      rx_sb_size <= RST_SIZE;
      tx_pt_size <= RST_SIZE;
      rx_pt_size <= RST_SIZE;
      img_bytes  <= 12'h000;
      sel        <= 1'b0;
      img_valid  <= 1'b0;
      short_fmt  <= 1'b0;
      trace_en   <= '0;
    end
    else if (wr_acc)
    begin
      if (hit_ar)
        ar_size <= PWDATA[7:0];
      if (hit_sb)
      begin
        tx_sb_size <= PWDATA[7:0];
        rx_sb_size <= PWDATA[15:8];
      end
      if (hit_pt)
      begin
        tx_pt_size <= PWDATA[7:0];
        rx_pt_size <= PWDATA[15:8];
      end
      // no bound is enforced; software keeps it within 1024 bytes
      if (hit_img)
        img_bytes <= PWDATA[11:0];
      if (hit_ctl)
      begin
        sel       <= PWDATA[CTL_SELECT];
        img_valid <= PWDATA[CTL_VALID];
        short_fmt <= PWDATA[CTL_SHORT];
        trace_en  <= PWDATA[CTL_EN_LO +: N_TYPES];
      end
    end
  end

  // ==========================================================
  // image address pointer
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      ptr <= RST_PTR;
    else if (wr_acc & hit_ctl)
      ptr <= {1'b0, PWDATA[CTL_PTR_LO +: 11]};
    else if (ptr_step)
      ptr <= ptr + QUAD_STEP;
  end

  // ==========================================================
  // trace pointers and count
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      wr_pos <= 7'h00;
      rd_pos <= 7'h00;
      count  <= 7'h00;
    end
    // resizing the partition discards whatever trace was held
    else if (wr_acc & (hit_ar | hit_sb | hit_pt))
    begin
      wr_pos <= 7'h00;
      rd_pos <= 7'h00;
      count  <= 7'h00;
    end
    else
    begin
      if (push)
        wr_pos <= wr_next;
      if (pop | drop_old)
        rd_pos <= rd_next;
      if (push & ~pop & ~trace_full)
        count <= count + 7'h01;
      else if (pop & ~push)
        count <= count - 7'h01;
    end
  end

  // ==========================================================
  // buffer entries; a trace push wins over an image write
  genvar g;
  generate
    for (g = 0; g < BUF_QUADS; g++)
    begin : g_entry
      wire tr_hit = push & (wr_abs == 8'(g));
      wire im_hit = img_wr & ({1'b0, ptr_idx} == 8'(g));
      always_ff @(posedge CLOCK)
      begin
        if (RST)
          mem[g] <= 32'h0;
        else if (tr_hit)
          mem[g] <= TRACE_IN.data;
        else if (im_hit)
          mem[g] <= PWDATA;
      end
    end
  endgenerate

  // ==========================================================
  // automatic image read responder
  wire [11:0] req_rel  = ROM_REQ.offset - IMAGE_BASE;
  wire [9:0]  req_quad = req_rel[11:2];
  wire        req_in   = (ROM_REQ.offset >= IMAGE_BASE)
                       & (req_quad < {2'h0, ar_size});
  wire [6:0]  req_idx  = req_quad[6:0];

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      ROM_ANS <= '0;
    else
    begin
      ROM_ANS.done    <= ROM_REQ.req;
      ROM_ANS.tardy   <= ROM_REQ.req & ~img_valid;
      ROM_ANS.data_ok <= ROM_REQ.req & img_valid & req_in;
      // beyond the auto-response area the host must answer
      ROM_ANS.to_host <= ROM_REQ.req & img_valid & ~req_in;
      ROM_ANS.data    <= (ROM_REQ.req & img_valid & req_in)
                       ? mem[req_idx] : 32'h0;
    end
  end

endmodule

//--- hw/crl_pkg.sv
// constants and types shared by the configuration image and trace buffer
//
// Notes on behaviour
// - The five area sizes plus the trace area must add up to the 126-quadlet shared buffer.
// - Bus reads from the image base up to the auto-response size are answered by the block alone.
// - With the select bit set, each data port write stores a quadlet at the pointer if it lies in the auto-response area, then advances the pointer by one quadlet.
// - After the pointer is rewritten with the select bit set, data port reads return the stored image in order.
// - While the valid flag is clear, every image read request is answered with a tardy acknowledge.
// - Only transaction types whose enable bits are set are recorded in the trace area.
// - Reads of the data port with the select bit clear return recorded trace quadlets in order.
// - In header-only mode the payload quadlets of a packet are dropped and only header and trailer kept.
// - A count field reports how many trace quadlets are held.
// - When the trace area is full a new quadlet overwrites the oldest; a count equal to the size means full.
package crl_pkg;

  // ==========================================================
  // buffer geometry
  localparam int          BUF_QUADS     = 126;
  localparam logic [7:0]  BUF_QUADS_B   = 8'h7e;
  localparam logic [11:0] IMAGE_BASE    = 12'h400;
  localparam logic [11:0] AR_MAX_BYTES  = 12'h1f8;
  localparam logic [11:0] IMG_MAX_BYTES = 12'h400;
  localparam logic [11:0] QUAD_STEP     = 12'h004;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_AR_SIZE   = 8'h8c;
  localparam logic [7:0] OFF_SB_SIZES  = 8'h94;
  localparam logic [7:0] OFF_PT_SIZES  = 8'h98;
  localparam logic [7:0] OFF_IMG_BYTES = 8'hf0;
  localparam logic [7:0] OFF_CONTROL   = 8'hf8;
  localparam logic [7:0] OFF_DATA      = 8'hfc;

  // ==========================================================
  // control register fields
  localparam int CTL_SELECT  = 0;
  localparam int CTL_VALID   = 1;
  localparam int CTL_SHORT   = 2;
  localparam int CTL_FAULT   = 3;
  localparam int CTL_EN_LO   = 4;
  localparam int CTL_CNT_LO  = 8;
  localparam int CTL_PTR_LO  = 16;
  localparam int N_TYPES     = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_SIZE = 8'h00;
  localparam logic [11:0] RST_PTR  = 12'h400;

  // ==========================================================
  // carriers
  typedef enum logic [1:0] {CRL_HDR, CRL_PAYLOAD, CRL_TRAILER} crl_kind_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  ttype;
    crl_kind_e   kind;
    logic [31:0] data;
  } crl_trace_s;

  typedef struct packed {
    logic        req;
    logic [11:0] offset;
  } crl_rom_req_s;

  typedef struct packed {
    logic        done;
    logic        data_ok;
    logic        tardy;
    logic        to_host;
    logic [31:0] data;
  } crl_rom_ans_s;

endpackage

//--- verif/crl_buffer_assertions.sv
// port-level assertions for the image and trace buffer
`timescale 1ns/1ps
module crl_buffer_assertions
import crl_pkg::*;
(
  input wire logic         CLOCK,
  input wire logic         RST,
  input wire logic         PSEL,
  input wire logic         PENABLE,
  input wire logic         PWRITE,
  input wire logic [7:0]   PADDR,
  input wire logic [31:0]  PWDATA,
  input wire logic [31:0]  PRDATA,
  input wire logic         PREADY,
  input wire logic         PSLVERR,
  input wire crl_rom_req_s ROM_REQ,
  input wire crl_rom_ans_s ROM_ANS,
  input wire crl_trace_s   TRACE_IN
);
  // ====
  // shadow of the valid flag, taken at the apb access edge
  logic valid_q;
  always_ff @(posedge CLOCK)
    if (RST)
      valid_q <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PADDR == OFF_CONTROL)
      valid_q <= PWDATA[CTL_VALID];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence access_s; PSEL && PENABLE; endsequence

  apb_ready_a:
    assert property (setup_s ##1 access_s |-> PREADY)
    else $error("access cycle without ready");
  rom_answer_a:
    assert property (ROM_REQ.req |=> ROM_ANS.done)
    else $error("image read not answered next cycle");
  no_spurious_a:
    assert property (!ROM_REQ.req |=> !ROM_ANS.done)
    else $error("image answer without request");
  one_kind_a:
    assert property (ROM_ANS.done |->
      $onehot({ROM_ANS.data_ok, ROM_ANS.tardy, ROM_ANS.to_host}))
    else $error("image answer kind not unique");
  data_gate_a:
    assert property (!ROM_ANS.data_ok |-> ROM_ANS.data == 32'h0)
    else $error("image data without data flag");
  tardy_invalid_a:
    assert property (ROM_REQ.req && !valid_q |=> ROM_ANS.tardy)
    else $error("invalid image not answered tardy");
  host_low_a:
    assert property (ROM_REQ.req && valid_q && ROM_REQ.offset < IMAGE_BASE
      |=> ROM_ANS.to_host)
    else $error("read below image not passed on");
  count_bound_a:
    assert property (access_s and !PWRITE && PADDR == OFF_CONTROL
      |-> PRDATA[14:8] <= 7'h7e)
    else $error("trace count above buffer size");
endmodule

bind crl_buffer crl_buffer_assertions u_chk (.CLOCK(CLOCK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ROM_REQ(ROM_REQ), .ROM_ANS(ROM_ANS), .TRACE_IN(TRACE_IN));

//--- verif/crl_remote_node.sv
// model of the far side: remote image reads and trace traffic
`timescale 1ns/1ps
module crl_remote_node
import crl_pkg::*;
(
  input wire logic CLOCK,
  output crl_rom_req_s ROM_REQ,
  output crl_trace_s   TRACE_IN
);
  initial ROM_REQ = '0;
  initial TRACE_IN = '0;
  // ====
  // idle offset, type and data fields show the inverse so stale values are never trusted
  task automatic rom_read(input logic [11:0] off);
    ROM_REQ <= '{req: 1'b1, offset: off};
    @(posedge CLOCK);
    ROM_REQ <= '{req: 1'b0, offset: ~off};
    @(posedge CLOCK);
  endtask
  task automatic push(input logic [1:0] t, input crl_kind_e k,
                      input logic [31:0] d);
    TRACE_IN <= '{valid: 1'b1, ttype: t, kind: k, data: d};
    @(posedge CLOCK);
    TRACE_IN <= '{valid: 1'b0, ttype: ~t, kind: k, data: ~d};
    @(posedge CLOCK);
  endtask
endmodule

//--- verif/test_crl_buffer.sv
// self-checking bench for the image and trace buffer
`timescale 1ns/1ps
module test_crl_buffer;
  import crl_pkg::*;
  localparam logic [35:0] M = 36'hf_ffff_ffff;
  logic         CLOCK = 1'b0, RST = 1'b1, PSEL = 1'b0;
  logic         PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
  logic [7:0]   PADDR = 8'h00;
  logic [31:0]  PWDATA = 32'h0, PRDATA, d, seed = 32'hf507;
  logic [31:0]  img[8];
  logic [35:0]  exp_q[$], msk_q[$];
  crl_rom_req_s ROM_REQ;
  crl_rom_ans_s ROM_ANS;
  crl_trace_s   TRACE_IN;
  int           fail_count = 0, checked = 0;

  crl_buffer u_dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ROM_REQ(ROM_REQ), .ROM_ANS(ROM_ANS), .TRACE_IN(TRACE_IN));
  crl_remote_node u_node (.CLOCK(CLOCK), .ROM_REQ(ROM_REQ),
    .TRACE_IN(TRACE_IN));

  initial forever #4 CLOCK = ~CLOCK;

  // ====
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [35:0] s, e, m);
    checked++;
    if ((s & m) !== (e & m))
    begin
      fail_count++;
      $display("mismatch result expected %h seen %h", e & m, s & m);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // unexpected results compare against their own inverse and so fail
  task automatic take(input logic [35:0] s);
    if (exp_q.size() == 0)
      check(s, ~s, M);
    else
      check(s, exp_q.pop_front(), msk_q.pop_front());
  endtask
  always @(posedge CLOCK)
  begin
    if (!RST && PSEL && PENABLE && PREADY && !PWRITE)
      take({PSLVERR, 3'h0, PRDATA});
    if (!RST && ROM_ANS.done)
      take({1'b0, ROM_ANS.data_ok, ROM_ANS.tardy, ROM_ANS.to_host,
            ROM_ANS.data});
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end while (!PREADY && n < 20);
    if (!PREADY)
    begin
      fail_count++;
      complete_run();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [35:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rom(input logic [11:0] o, input logic [2:0] f,
                     input logic [31:0] v);
    exp_q.push_back({1'b0, f, v});
    msk_q.push_back(M);
    u_node.rom_read(o);
  endtask

  // ====
  // main sequence
  initial
  begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(8'h10, {1'b1, 35'h0}, M);
    apb(1'b1, OFF_AR_SIZE, 32'h8);
    apb(1'b1, OFF_SB_SIZES, 32'h0);
    apb(1'b1, OFF_PT_SIZES, 32'h0);
    rd(OFF_AR_SIZE, 36'h8, M);
    // an eight-quadlet image fits the auto area, so total equals it
    apb(1'b1, OFF_IMG_BYTES, 32'h20);
    rd(OFF_IMG_BYTES, 36'h20, M);
    rom(IMAGE_BASE, 3'b010, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h0400_0001);
    for (int i = 0; i < 8; i++)
    begin
      img[i] = xs();
      apb(1'b1, OFF_DATA, img[i]);
    end
    apb(1'b1, OFF_CONTROL, 32'h0400_0001);
    for (int i = 0; i < 8; i++)
      rd(OFF_DATA, {4'h0, img[i]}, M);
    rd(OFF_CONTROL, 36'h420_0000, 36'h7ff_0000);
    apb(1'b1, OFF_CONTROL, 32'h0400_00f2);
    for (int i = 0; i < 8; i++)
      rom(IMAGE_BASE + 12'(4 * i), 3'b100, img[i]);
    rom(12'h420, 3'b001, 32'h0);
    rom(12'h3fc, 3'b001, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h0400_0036);
    d = xs();
    u_node.push(2'h2, CRL_HDR, d);
    u_node.push(2'h0, CRL_HDR, d + 32'h1);
    u_node.push(2'h0, CRL_PAYLOAD, d + 32'h2);
    u_node.push(2'h0, CRL_TRAILER, d + 32'h3);
    u_node.push(2'h1, CRL_HDR, d + 32'h4);
    rd(OFF_CONTROL, 36'h300, 36'h7f00);
    rd(OFF_DATA, {4'h0, d + 32'h1}, M);
    rd(OFF_DATA, {4'h0, d + 32'h3}, M);
    rd(OFF_DATA, {4'h0, d + 32'h4}, M);
    rd(OFF_DATA, 36'h0, M);
    for (int i = 0; i < 120; i++)
      u_node.push(2'h0, CRL_HDR, 32'(i));
    rd(OFF_CONTROL, 36'h7600, 36'h7f00);
    rd(OFF_DATA, 36'h2, M);
    // oversized partition: fault set and no trace area left
    apb(1'b1, OFF_SB_SIZES, 32'h7f7f);
    u_node.push(2'h0, CRL_HDR, 32'h5);
    rd(OFF_SB_SIZES, 36'h7f7f, M);
    rd(OFF_CONTROL, 36'h8, 36'h7f08);
    // reset in mid-run returns every register to its idle value
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(OFF_CONTROL, 36'h400_0000, M);
    rd(OFF_SB_SIZES, 36'h0, M);
    rom(IMAGE_BASE, 3'b010, 32'h0);
    repeat (3) @(posedge CLOCK);
    if (exp_q.size() != 0)
      fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    complete_run();
  end
endmodule
